/* File: ewm_pkg.sv */
// constants shared by the extended write and sector marking block
// How it works
// (RQ1) command 34h takes host sectors, then commits each one to the medium
// (RQ2) sector payload moves through the data port as 16-bit words
// (RQ3) an uncorrectable write error stops the command at the failing sector
// (RQ4) host puts count bits 7:0 in current byte, 15:8 in previous byte
// (RQ5) a sector count of 0000h means 65,536 sectors
// (RQ6) host loads address bytes 7:0..23:16 current, 31:24..47:40 previous
// (RQ7) high byte select clear: address bytes return error address bits 23:0
// (RQ8) high byte select set: address bytes return error address bits 47:24
// (RQ9) command 45h marks addressed sectors so later reads report uncorrectable
// (RQ10) feature 55h marks every sector of the 4KB block as pseudo bad
// (RQ11) pseudo bad read: run recovery first, then set uncorrectable and error
// (RQ12) feature AAh marks only the addressed sectors as flagged bad
// (RQ13) flagged bad read: set uncorrectable and error at once, no recovery
// (RQ14) reads of 55h-marked sectors are logged as failures
// (RQ15) reads of AAh-marked sectors are never logged
// (RQ16) sector marks survive power loss and device reset
// (RQ17) a marking command that cannot be done ends with command aborted
// (RQ18) any feature other than 55h or AAh aborts the marking command
// (RQ19) marking uses the 16-bit sector count as consecutive sectors to mark
// (RQ20) host sets device register bit 6 for block addressing first
// (RQ21) busy rises within 5 us after the host delivers sector data
package ewm_pkg;
	// command and feature codes
	localparam logic [7:0]  CMD_WRITE_EXT     = 8'h34;
	localparam logic [7:0]  CMD_MARK_UNC      = 8'h45;
	localparam logic [7:0]  FEAT_PSEUDO       = 8'h55;
	localparam logic [7:0]  FEAT_FLAGGED      = 8'hAA;
	// task file selects
	localparam logic [3:0]  SEL_FEATURE_ERROR = 4'h1;
	localparam logic [3:0]  SEL_COUNT         = 4'h2;
	localparam logic [3:0]  SEL_ADDR_LOW      = 4'h3;
	localparam logic [3:0]  SEL_ADDR_MID      = 4'h4;
	localparam logic [3:0]  SEL_ADDR_HIGH     = 4'h5;
	localparam logic [3:0]  SEL_DEVICE        = 4'h6;
	localparam logic [3:0]  SEL_CMD_STATUS    = 4'h7;
	localparam logic [3:0]  SEL_DEV_CONTROL   = 4'h8;
	// bit positions
	localparam int          STATUS_BUSY_BIT   = 7;
	localparam int          STATUS_READY_BIT  = 6;
	localparam int          STATUS_DRQ_BIT    = 3;
	localparam int          STATUS_ERR_BIT    = 0;
	localparam int          ERROR_UNC_BIT     = 6;
	localparam int          ERROR_IDNF_BIT    = 4;
	localparam int          ERROR_ABORT_BIT   = 2;
	localparam int          DEVCTL_HOB_BIT    = 7;
	localparam int          DEVICE_LBA_BIT    = 6;
	// reset values and the total for a zero sector count
	localparam logic [7:0]  REG_RESET         = 8'h00;
	localparam logic [47:0] LBA_RESET         = 48'h0000_0000_0000;
	localparam logic [16:0] ZERO_COUNT_TOTAL  = 17'h1_0000;
	// geometry
	localparam int          SECTOR_WORDS      = 256;
	localparam int          BLOCK_SECTORS     = 8;
	localparam int          MARK_DEPTH        = 1024;
	// timing
	localparam int          CLK_PERIOD_NS     = 10;
	localparam int          BUSY_AFTER_DATA_NS = 5000;
	localparam int          BUSY_AFTER_DATA_CYC =
		BUSY_AFTER_DATA_NS / CLK_PERIOD_NS;
endpackage : ewm_pkg

/* File: ewm_mark_store.sv */
// retained store of pseudo and flagged uncorrectable sector marks
`timescale 1ns/10ps
module ewm_mark_store #(
	parameter int DEPTH         = ewm_pkg::MARK_DEPTH,
	parameter int BLOCK_SECTORS = ewm_pkg::BLOCK_SECTORS
) (
	// clock
	input  wire logic        clk_in,
	// mark write
	input  wire logic        mark_we_in,
	input  wire logic        mark_pseudo_in,
	input  wire logic [47:0] mark_lba_in,
	// lookup
	input  wire logic [47:0] query_lba_in,
	output logic             pseudo_hit_out,
	output logic             flagged_hit_out
);
	import ewm_pkg::*;

	localparam int IDX_W = $clog2(DEPTH);
	localparam int BLK_W = $clog2(BLOCK_SECTORS);

	logic flagged_mem [0:DEPTH-1] = '{default: 1'b0};
	logic pseudo_mem  [0:(DEPTH/BLOCK_SECTORS)-1] = '{default: 1'b0};

	function automatic logic [IDX_W-1:0] sector_index(
		input logic [47:0] lba);
		sector_index = lba[IDX_W-1:0];
	endfunction : sector_index

	function automatic logic [IDX_W-BLK_W-1:0] block_index(
		input logic [47:0] lba);
		block_index = lba[IDX_W-1:BLK_W];
	endfunction : block_index

	// no reset: marks outlive reset and power loss [RQ16]
	always_ff @(posedge clk_in) begin
		if (mark_we_in && mark_pseudo_in) begin
			pseudo_mem[block_index(mark_lba_in)] <= 1'b1; // [RQ10]
		end
	end

	always_ff @(posedge clk_in) begin
		if (mark_we_in && !mark_pseudo_in) begin
			flagged_mem[sector_index(mark_lba_in)] <= 1'b1; // [RQ12]
		end
	end

	assign pseudo_hit_out  = pseudo_mem[block_index(query_lba_in)];
	assign flagged_hit_out = flagged_mem[sector_index(query_lba_in)];
endmodule : ewm_mark_store

/* File: ewm_cmd_top.sv */
// task file command interpreter for extended write and sector marking
`timescale 1ns/10ps
module ewm_cmd_top #(
	parameter int SECTOR_WORDS = ewm_pkg::SECTOR_WORDS,
	parameter int MARK_DEPTH   = ewm_pkg::MARK_DEPTH
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	// task file port
	input  wire logic        tf_wr_in,
	input  wire logic        tf_rd_in,
	input  wire logic [3:0]  tf_sel_in,
	input  wire logic [7:0]  tf_wdata_in,
	output logic      [7:0]  tf_rdata_out,
	// data port
	input  wire logic        data_wr_in,
	input  wire logic [15:0] data_in,
	output logic             data_req_out,
	output logic             cmd_done_out,
	// medium write side
	output logic             media_word_valid_out,
	output logic      [15:0] media_word_out,
	output logic      [47:0] media_lba_out,
	output logic             media_commit_out,
	input  wire logic        media_commit_done_in,
	input  wire logic        media_commit_err_in,
	// read check side
	input  wire logic        rd_req_in,
	input  wire logic [47:0] rd_lba_in,
	output logic             rd_done_out,
	output logic             rd_unc_out,
	output logic             recover_req_out,
	input  wire logic        recover_done_in,
	output logic             log_valid_out,
	output logic      [47:0] log_lba_out
);
	import ewm_pkg::*;

	localparam int WC_W = $clog2(SECTOR_WORDS);

	typedef enum {
		ST_IDLE,
		ST_WR_DATA,
		ST_WR_COMMIT,
		ST_MARK
	} ewm_state_e;

	typedef enum {
		RC_IDLE,
		RC_RECOVER
	} ewm_rchk_e;

	ewm_state_e      state_reg;
	ewm_rchk_e       rchk_reg;
	logic [7:0]      feature_reg;
	logic [7:0]      count_cur_reg;
	logic [7:0]      count_prev_reg;
	logic [7:0]      addr_cur_reg [0:2];
	logic [7:0]      addr_prev_reg [0:2];
	logic [7:0]      device_reg;
	logic            hob_reg;
	logic [7:0]      error_reg;
	logic            err_flag_reg;
	logic [47:0]     cur_lba_reg;
	logic [16:0]     remain_reg;
	logic [WC_W-1:0] word_cnt_reg;
	logic            mark_pseudo_reg;
	logic [47:0]     rchk_lba_reg;
	logic            rchk_log_reg;

	logic            cmd_take;
	logic            idle;
	logic [47:0]     cmd_lba;
	logic [16:0]     cmd_total;
	logic            mark_abort;
	logic            bad_cmd;
	logic            write_fail;
	logic            write_ok;
	logic            finish;
	logic            pseudo_hit;
	logic            flagged_hit;
	logic            rchk_unc;
	logic [7:0]      status_val;

	// 16-bit count from its two bytes, zero meaning the full range
	function automatic logic [16:0] sector_total(
		input logic [7:0] hi, input logic [7:0] lo);
		if ({hi, lo} == 16'h0000) begin
			sector_total = ZERO_COUNT_TOTAL; // [RQ5]
		end else begin
			sector_total = {1'b0, hi, lo};
		end
	endfunction : sector_total

	// 48-bit address from current and previous bytes
	function automatic logic [47:0] lba_from(
		input logic [7:0] p2, input logic [7:0] p1, input logic [7:0] p0,
		input logic [7:0] c2, input logic [7:0] c1, input logic [7:0] c0);
		lba_from = {p2, p1, p0, c2, c1, c0};
	endfunction : lba_from

	assign idle      = (state_reg == ST_IDLE);
	assign cmd_take  = tf_wr_in && idle && (tf_sel_in == SEL_CMD_STATUS);
	assign cmd_lba   = lba_from(addr_prev_reg[2], addr_prev_reg[1],
		addr_prev_reg[0], addr_cur_reg[2], addr_cur_reg[1],
		addr_cur_reg[0]); // [RQ6]
	assign cmd_total = sector_total(count_prev_reg, count_cur_reg); // [RQ4]
	assign mark_abort = (feature_reg != FEAT_PSEUDO
		&& feature_reg != FEAT_FLAGGED) // [RQ18]
		|| (({1'b0, cmd_lba} + {32'h0000_0000, cmd_total})
		> 49'(MARK_DEPTH)); // [RQ17]
	assign bad_cmd   = cmd_take && ((tf_wdata_in == CMD_MARK_UNC && mark_abort)
		|| (tf_wdata_in != CMD_MARK_UNC && tf_wdata_in != CMD_WRITE_EXT));
	assign write_fail = (state_reg == ST_WR_COMMIT) && media_commit_done_in
		&& media_commit_err_in;
	assign write_ok   = (state_reg == ST_WR_COMMIT) && media_commit_done_in
		&& !media_commit_err_in;
	assign finish     = write_fail || bad_cmd
		|| ((write_ok || state_reg == ST_MARK) && remain_reg == 17'h0_0001);

	// handshakes
	assign data_req_out     = (state_reg == ST_WR_DATA);
	assign media_commit_out = (state_reg == ST_WR_COMMIT); // [RQ1]
	assign recover_req_out  = (rchk_reg == RC_RECOVER); // [RQ11]

	// command sequencer
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (cmd_take && !bad_cmd) begin
						if (tf_wdata_in == CMD_WRITE_EXT) begin
							state_reg <= ST_WR_DATA; // [RQ1]
						end else begin
							state_reg <= ST_MARK; // [RQ9]
						end
					end
				end
				ST_WR_DATA: begin
					if (data_wr_in && word_cnt_reg == WC_W'(SECTOR_WORDS - 1)) begin
						state_reg <= ST_WR_COMMIT; // [RQ21]
					end
				end
				ST_WR_COMMIT: begin
					if (finish) begin
						state_reg <= ST_IDLE; // [RQ3]
					end else if (write_ok) begin
						state_reg <= ST_WR_DATA;
					end
				end
				ST_MARK: begin
					if (finish) begin
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// working address, remaining count and word count
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cur_lba_reg     <= LBA_RESET;
			remain_reg      <= 17'h0_0000;
			word_cnt_reg    <= '0;
			mark_pseudo_reg <= 1'b0;
		end else if (cmd_take) begin
			cur_lba_reg     <= cmd_lba;
			remain_reg      <= cmd_total; // [RQ19]
			word_cnt_reg    <= '0;
			mark_pseudo_reg <= (feature_reg == FEAT_PSEUDO);
		end else if (state_reg == ST_WR_DATA && data_wr_in) begin
			word_cnt_reg <= word_cnt_reg + 1'b1; // [RQ2]
		end else if (write_ok || state_reg == ST_MARK) begin
			cur_lba_reg <= cur_lba_reg + 48'h0000_0000_0001;
			remain_reg  <= remain_reg - 17'h0_0001;
		end
	end

	// word stream to the medium
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			media_word_valid_out <= 1'b0;
			media_word_out       <= 16'h0000;
			media_lba_out        <= LBA_RESET;
		end else begin
			media_word_valid_out <= (state_reg == ST_WR_DATA) && data_wr_in;
			if (state_reg == ST_WR_DATA && data_wr_in) begin
				media_word_out <= data_in; // [RQ2]
				media_lba_out  <= cur_lba_reg;
			end
		end
	end

	// completion pulse
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			cmd_done_out <= 1'b0;
		end else begin
			cmd_done_out <= finish;
		end
	end

	// host written shadow registers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			feature_reg    <= REG_RESET;
			count_cur_reg  <= REG_RESET;
			count_prev_reg <= REG_RESET;
			device_reg     <= REG_RESET;
			hob_reg        <= 1'b0;
		end else if (tf_wr_in && idle) begin
			case (tf_sel_in)
				SEL_FEATURE_ERROR: feature_reg <= tf_wdata_in;
				SEL_COUNT: begin
					count_prev_reg <= count_cur_reg; // [RQ4]
					count_cur_reg  <= tf_wdata_in;
				end
				SEL_DEVICE:      device_reg <= tf_wdata_in; // [RQ20]
				SEL_DEV_CONTROL: hob_reg <= tf_wdata_in[DEVCTL_HOB_BIT];
				default: begin
				end
			endcase
		end
	end

	// address bytes, overwritten by the failing sector address
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			for (int i = 0; i < 3; i++) begin
				addr_cur_reg[i]  <= REG_RESET;
				addr_prev_reg[i] <= REG_RESET;
			end
		end else if (write_fail) begin
			for (int i = 0; i < 3; i++) begin
				addr_cur_reg[i]  <= cur_lba_reg[8*i +: 8]; // [RQ7]
				addr_prev_reg[i] <= cur_lba_reg[24 + 8*i +: 8]; // [RQ8]
			end
		end else if (tf_wr_in && idle && tf_sel_in >= SEL_ADDR_LOW
			&& tf_sel_in <= SEL_ADDR_HIGH) begin
			for (int i = 0; i < 3; i++) begin
				if (tf_sel_in == SEL_ADDR_LOW + 4'(i)) begin
					addr_prev_reg[i] <= addr_cur_reg[i]; // [RQ6]
					addr_cur_reg[i]  <= tf_wdata_in;
				end
			end
		end
	end

	// error and error flag, sets win over the command clear
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			error_reg    <= REG_RESET;
			err_flag_reg <= 1'b0;
		end else if (bad_cmd) begin
			error_reg    <= 8'h00 | (8'h01 << ERROR_ABORT_BIT); // [RQ17]
			err_flag_reg <= 1'b1;
		end else if (write_fail || rchk_unc) begin
			error_reg[ERROR_UNC_BIT] <= 1'b1; // [RQ3] [RQ13]
			err_flag_reg             <= 1'b1;
		end else if (cmd_take) begin
			error_reg    <= REG_RESET;
			err_flag_reg <= 1'b0;
		end
	end

	// register read data
	always_comb begin
		status_val = REG_RESET;
		status_val[STATUS_BUSY_BIT]  = !idle && !data_req_out; // [RQ21]
		status_val[STATUS_READY_BIT] = 1'b1;
		status_val[STATUS_DRQ_BIT]   = data_req_out;
		status_val[STATUS_ERR_BIT]   = err_flag_reg;
	end

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			tf_rdata_out <= REG_RESET;
		end else if (tf_rd_in) begin
			case (tf_sel_in)
				SEL_FEATURE_ERROR: tf_rdata_out <= error_reg;
				SEL_COUNT: tf_rdata_out <= hob_reg ? count_prev_reg
					: count_cur_reg;
				SEL_ADDR_LOW: tf_rdata_out <= hob_reg ? addr_prev_reg[0]
					: addr_cur_reg[0]; // [RQ7] [RQ8]
				SEL_ADDR_MID: tf_rdata_out <= hob_reg ? addr_prev_reg[1]
					: addr_cur_reg[1]; // [RQ7] [RQ8]
				SEL_ADDR_HIGH: tf_rdata_out <= hob_reg ? addr_prev_reg[2]
					: addr_cur_reg[2]; // [RQ7] [RQ8]
				SEL_DEVICE:     tf_rdata_out <= device_reg;
				SEL_CMD_STATUS: tf_rdata_out <= status_val;
				default:        tf_rdata_out <= REG_RESET;
			endcase
		end
	end

	// mark store, also looked up by read checks
	ewm_mark_store #(
		.DEPTH         (MARK_DEPTH),
		.BLOCK_SECTORS (BLOCK_SECTORS)
	) u_marks (
		.clk_in          (clk_in),
		.mark_we_in      (state_reg == ST_MARK), // [RQ9]
		.mark_pseudo_in  (mark_pseudo_reg), // [RQ10] [RQ12]
		.mark_lba_in     (cur_lba_reg),
		.query_lba_in    (rd_lba_in),
		.pseudo_hit_out  (pseudo_hit),
		.flagged_hit_out (flagged_hit)
	);

	// read check sequencer
	assign rchk_unc = (rchk_reg == RC_IDLE && rd_req_in && flagged_hit)
		|| (rchk_reg == RC_RECOVER && recover_done_in);

	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rchk_reg     <= RC_IDLE;
			rchk_lba_reg <= LBA_RESET;
			rchk_log_reg <= 1'b0;
		end else begin
			case (rchk_reg)
				RC_IDLE: begin
					if (rd_req_in) begin
						rchk_lba_reg <= rd_lba_in;
						if (!flagged_hit && pseudo_hit) begin
							rchk_reg     <= RC_RECOVER; // [RQ11]
							rchk_log_reg <= 1'b1;
						end
					end
				end
				RC_RECOVER: begin
					if (recover_done_in) begin
						rchk_reg     <= RC_IDLE;
						rchk_log_reg <= 1'b0;
					end
				end
				default: begin
					rchk_reg <= RC_IDLE;
				end
			endcase
		end
	end

	// read check answers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rd_done_out   <= 1'b0;
			rd_unc_out    <= 1'b0;
			log_valid_out <= 1'b0;
			log_lba_out   <= LBA_RESET;
		end else begin
			rd_done_out   <= (rchk_reg == RC_IDLE && rd_req_in
				&& (flagged_hit || !pseudo_hit)) || (rchk_reg == RC_RECOVER
				&& recover_done_in);
			log_valid_out <= rchk_reg == RC_RECOVER && recover_done_in
				&& rchk_log_reg; // [RQ14] [RQ15]
			if (rchk_reg == RC_IDLE && rd_req_in) begin
				rd_unc_out <= flagged_hit; // [RQ13]
			end else if (rchk_reg == RC_RECOVER && recover_done_in) begin
				rd_unc_out  <= 1'b1; // [RQ11]
				log_lba_out <= rchk_lba_reg; // [RQ14]
			end
		end
	end
endmodule : ewm_cmd_top

/* File: ewm_monitor.sv */
// port assertions for the command interpreter
`timescale 1ns/10ps
module ewm_monitor (
	// clock and reset
	input wire logic        clk_in,
	input wire logic        reset_in,
	// task file and data port
	input wire logic        tf_wr_in,
	input wire logic [3:0]  tf_sel_in,
	input wire logic [7:0]  tf_wdata_in,
	input wire logic        data_wr_in,
	input wire logic [15:0] data_in,
	input wire logic        data_req_out,
	input wire logic        cmd_done_out,
	// medium and read check
	input wire logic        media_word_valid_out,
	input wire logic [15:0] media_word_out,
	input wire logic        media_commit_out,
	input wire logic        media_commit_done_in,
	input wire logic        media_commit_err_in,
	input wire logic        rd_done_out,
	input wire logic        rd_unc_out,
	input wire logic        recover_req_out,
	input wire logic        recover_done_in,
	input wire logic        log_valid_out
);
	import ewm_pkg::*;
	localparam int BUSY_LIMIT = 500;
	logic       idle_reg;
	logic [7:0] feat_reg;
	logic       cmd_wr;
	assign cmd_wr = tf_wr_in && idle_reg && tf_sel_in == SEL_CMD_STATUS;
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			idle_reg <= 1'b1;
		end else if (cmd_wr) begin
			idle_reg <= 1'b0;
		end else if (cmd_done_out) begin
			idle_reg <= 1'b1;
		end
	end
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			feat_reg <= 8'h00;
		end else if (tf_wr_in && idle_reg && tf_sel_in == SEL_FEATURE_ERROR) begin
			feat_reg <= tf_wdata_in;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	word_echo_a: assert property (data_wr_in && data_req_out |=>
		media_word_valid_out && media_word_out == $past(data_in))
		else $error("data word not passed to medium");
	stray_word_a: assert property (!(data_wr_in && data_req_out) |=>
		!media_word_valid_out) else $error("word sent without request");
	commit_hold_a: assert property (media_commit_out &&
		!media_commit_done_in |=> media_commit_out)
		else $error("commit request dropped early");
	busy_quick_a: assert property ($fell(data_req_out) |->
		##[0:BUSY_LIMIT] (media_commit_out || cmd_done_out))
		else $error("no busy after sector data");
	err_stop_a: assert property (media_commit_out && media_commit_done_in &&
		media_commit_err_in |=> cmd_done_out && !data_req_out)
		else $error("write went on after failing sector");
	recover_hold_a: assert property (recover_req_out && !recover_done_in
		|=> recover_req_out && !rd_done_out)
		else $error("answer before recovery finished");
	pseudo_answer_a: assert property (recover_req_out && recover_done_in
		|=> rd_done_out && rd_unc_out && log_valid_out)
		else $error("pseudo mark read not reported and logged");
	log_only_a: assert property (log_valid_out |->
		$past(recover_req_out) && rd_unc_out)
		else $error("log entry without pseudo mark");
	bad_feat_a: assert property (cmd_wr && tf_wdata_in == CMD_MARK_UNC &&
		feat_reg != FEAT_PSEUDO && feat_reg != FEAT_FLAGGED |=> cmd_done_out)
		else $error("reserved feature not aborted");
	done_quiet_a: assert property (cmd_done_out |->
		!data_req_out && !media_commit_out)
		else $error("command ended while transfer active");
	write_end_c: cover property (media_commit_out ##1 cmd_done_out);
	commit_err_c: cover property (media_commit_done_in && media_commit_err_in);
	log_c: cover property (log_valid_out);
endmodule : ewm_monitor

/* File: ewm_media_model.sv */
// medium and recovery responder facing the command block
`timescale 1ns/10ps
module ewm_media_model (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	// commit side
	input  wire logic        commit_req_in,
	input  wire logic [47:0] lba_in,
	input  wire logic        err_en_in,
	input  wire logic [47:0] err_lba_in,
	output logic             commit_done_out,
	output logic             commit_err_out,
	// recovery side
	input  wire logic        recover_req_in,
	output logic             recover_done_out
);
	logic [1:0] commit_cnt;
	logic [1:0] rec_cnt;
	// commit answered after a few cycles, failing at one address
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			commit_cnt      <= 2'd0;
			commit_done_out <= 1'b0;
			commit_err_out  <= 1'b0;
		end else if (commit_req_in && !commit_done_out && commit_cnt == 2'd2) begin
			commit_cnt      <= 2'd0;
			commit_done_out <= 1'b1;
			commit_err_out  <= err_en_in && lba_in == err_lba_in;
		end else begin
			commit_cnt      <= commit_req_in && !commit_done_out ?
				commit_cnt + 2'd1 : 2'd0;
			commit_done_out <= 1'b0;
			commit_err_out  <= 1'b0;
		end
	end
	// normal recovery takes a few cycles
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			rec_cnt          <= 2'd0;
			recover_done_out <= 1'b0;
		end else if (recover_req_in && !recover_done_out && rec_cnt == 2'd2) begin
			rec_cnt          <= 2'd0;
			recover_done_out <= 1'b1;
		end else begin
			rec_cnt          <= recover_req_in && !recover_done_out ?
				rec_cnt + 2'd1 : 2'd0;
			recover_done_out <= 1'b0;
		end
	end
endmodule : ewm_media_model

/* File: tb.sv */
// testbench for the extended write and sector marking block
`timescale 1ns/10ps
module tb;
	import ewm_pkg::*;
	logic clk_in, reset_in, tf_wr_in, tf_rd_in, data_wr_in, rd_req_in;
	logic [3:0] tf_sel_in;
	logic [7:0] tf_wdata_in, tf_rdata_out, rv;
	logic [15:0] data_in, media_word_out;
	logic [47:0] rd_lba_in, media_lba_out, log_lba_out, err_lba, log_lba;
	logic data_req_out, cmd_done_out, media_word_valid_out, media_commit_out;
	logic media_commit_done_in, media_commit_err_in, rd_done_out, rd_unc_out;
	logic recover_req_out, recover_done_in, log_valid_out, err_en;
	int failures, checks, log_cnt, rec_cnt, i;
	ewm_cmd_top #(.SECTOR_WORDS(4), .MARK_DEPTH(64)) DUT (.clk_in(clk_in),
		.reset_in(reset_in), .tf_wr_in(tf_wr_in), .tf_rd_in(tf_rd_in),
		.tf_sel_in(tf_sel_in), .tf_wdata_in(tf_wdata_in),
		.tf_rdata_out(tf_rdata_out), .data_wr_in(data_wr_in), .data_in(data_in),
		.data_req_out(data_req_out), .cmd_done_out(cmd_done_out),
		.media_word_valid_out(media_word_valid_out),
		.media_word_out(media_word_out), .media_lba_out(media_lba_out),
		.media_commit_out(media_commit_out),
		.media_commit_done_in(media_commit_done_in),
		.media_commit_err_in(media_commit_err_in), .rd_req_in(rd_req_in),
		.rd_lba_in(rd_lba_in), .rd_done_out(rd_done_out),
		.rd_unc_out(rd_unc_out), .recover_req_out(recover_req_out),
		.recover_done_in(recover_done_in), .log_valid_out(log_valid_out),
		.log_lba_out(log_lba_out));
	ewm_media_model u_media (.clk_in(clk_in), .reset_in(reset_in),
		.commit_req_in(media_commit_out), .lba_in(media_lba_out),
		.err_en_in(err_en), .err_lba_in(err_lba),
		.commit_done_out(media_commit_done_in),
		.commit_err_out(media_commit_err_in),
		.recover_req_in(recover_req_out), .recover_done_out(recover_done_in));
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		if (log_valid_out === 1'b1) begin
			log_cnt++;
			log_lba = log_lba_out;
		end
		if (recover_req_out === 1'b1) rec_cnt++;
	end
	task automatic check(input string name, input logic [47:0] seen,
		input logic [47:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic finish_test;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : finish_test
	task automatic tf_write(input logic [3:0] sel, input logic [7:0] d);
		@(negedge clk_in);
		tf_wr_in = 1'b1;
		tf_sel_in = sel;
		tf_wdata_in = d;
		@(negedge clk_in);
		tf_wr_in = 1'b0;
	endtask : tf_write
	task automatic tf_read(input logic [3:0] sel);
		@(negedge clk_in);
		tf_rd_in = 1'b1;
		tf_sel_in = sel;
		@(negedge clk_in);
		tf_rd_in = 1'b0;
		rv = tf_rdata_out;
	endtask : tf_read
	task automatic load(input logic [7:0] cmd, input logic [7:0] feat,
		input logic [15:0] cnt, input logic [47:0] lba);
		int k;
		tf_write(SEL_COUNT, cnt[15:8]);
		tf_write(SEL_COUNT, cnt[7:0]);
		for (k = 0; k < 3; k++) begin
			tf_write(SEL_ADDR_LOW + 4'(k), lba[24+8*k +: 8]);
			tf_write(SEL_ADDR_LOW + 4'(k), lba[8*k +: 8]);
		end
		tf_write(SEL_DEVICE, 8'h40);
		tf_write(SEL_FEATURE_ERROR, feat);
		tf_write(SEL_CMD_STATUS, cmd);
	endtask : load
	task automatic wait_done(input int lim);
		int k;
		for (k = 0; k < lim && cmd_done_out !== 1'b1; k++) @(negedge clk_in);
		if (k == lim) begin
			failures++;
			finish_test();
		end
	endtask : wait_done
	task automatic send_words(input int n);
		int k, j;
		for (k = 0; k < n; k++) begin
			for (j = 0; j < 50 && data_req_out !== 1'b1; j++) @(negedge clk_in);
			if (j == 50) begin
				failures++;
				finish_test();
			end
			data_wr_in = 1'b1;
			data_in = 16'(16'h1100 + k);
			@(negedge clk_in);
			data_wr_in = 1'b0;
			@(negedge clk_in);
		end
	endtask : send_words
	task automatic status_is(input logic [7:0] st, input logic [7:0] er);
		tf_read(SEL_CMD_STATUS);
		check("status", 48'(rv), 48'(st));
		tf_read(SEL_FEATURE_ERROR);
		check("error", 48'(rv), 48'(er));
	endtask : status_is
	task automatic rd_check(input logic [47:0] lba, input logic uncorrectable_flag,
		input logic logged);
		int lc, rc, k;
		lc = log_cnt;
		rc = rec_cnt;
		@(negedge clk_in);
		rd_req_in = 1'b1;
		rd_lba_in = lba;
		@(negedge clk_in);
		rd_req_in = 1'b0;
		for (k = 0; k < 50 && rd_done_out !== 1'b1; k++) @(negedge clk_in);
		if (k == 50) failures++;
		@(negedge clk_in);
		check("read unc", 48'(rd_unc_out), 48'(uncorrectable_flag));
		check("log count", 48'(log_cnt - lc), 48'(logged));
		check("recovery", 48'(rec_cnt > rc), 48'(logged));
		if (logged) check("log lba", log_lba, lba);
	endtask : rd_check
	initial begin
		{tf_wr_in, tf_rd_in, data_wr_in, rd_req_in, err_en} = '0;
		tf_sel_in = 4'h0;
		tf_wdata_in = 8'h00;
		data_in = 16'h0000;
		rd_lba_in = '0;
		err_lba = 48'h0605_0403_0202;
		failures = 0;
		checks = 0;
		log_cnt = 0;
		rec_cnt = 0;
		reset_in = 1'b1;
		repeat (2) @(negedge clk_in);
		reset_in = 1'b0;
		status_is(8'h40, 8'h00);
		$display("test 1 done");
		load(CMD_WRITE_EXT, 8'h00, 16'h0002, 48'h0605_0403_0201);
		send_words(8);
		wait_done(100);
		status_is(8'h40, 8'h00);
		$display("test 2 done");
		err_en = 1'b1;
		load(CMD_WRITE_EXT, 8'h00, 16'h0003, 48'h0605_0403_0201);
		send_words(8);
		wait_done(100);
		status_is(8'h41, 8'h40);
		check("data req", 48'(data_req_out), 48'h0);
		for (i = 0; i < 3; i++) begin
			tf_read(SEL_ADDR_LOW + 4'(i));
			check("addr cur", 48'(rv), 48'(err_lba[8*i +: 8]));
		end
		tf_write(SEL_DEV_CONTROL, 8'h80);
		for (i = 0; i < 3; i++) begin
			tf_read(SEL_ADDR_LOW + 4'(i));
			check("addr prev", 48'(rv), 48'(err_lba[24+8*i +: 8]));
		end
		tf_write(SEL_DEV_CONTROL, 8'h00);
		err_en = 1'b0;
		$display("test 3 done");
		load(CMD_MARK_UNC, FEAT_PSEUDO, 16'h0001, 48'h0000_0000_0008);
		wait_done(100);
		status_is(8'h40, 8'h00);
		rd_check(48'h0000_0000_000D, 1'b1, 1'b1);
		$display("test 4 done");
		load(CMD_MARK_UNC, FEAT_FLAGGED, 16'h0002, 48'h0000_0000_0014);
		wait_done(100);
		status_is(8'h40, 8'h00);
		rd_check(48'h0000_0000_0015, 1'b1, 1'b0);
		$display("test 5 done");
		load(CMD_MARK_UNC, 8'h33, 16'h0001, 48'h0000_0000_0000);
		wait_done(100);
		status_is(8'h41, 8'h04);
		load(CMD_MARK_UNC, FEAT_FLAGGED, 16'h0008, 48'h0000_0000_003C);
		wait_done(100);
		status_is(8'h41, 8'h04);
		load(CMD_MARK_UNC, FEAT_FLAGGED, 16'h0000, 48'h0000_0000_0000);
		wait_done(100);
		status_is(8'h41, 8'h04);
		$display("test 6 done");
		reset_in = 1'b1;
		repeat (2) @(negedge clk_in);
		reset_in = 1'b0;
		rd_check(48'h0000_0000_0014, 1'b1, 1'b0);
		rd_check(48'h0000_0000_0009, 1'b1, 1'b1);
		$display("test 7 done");
		finish_test();
	end
endmodule : tb
bind ewm_cmd_top ewm_monitor u_mon (.clk_in(clk_in), .reset_in(reset_in),
	.tf_wr_in(tf_wr_in), .tf_sel_in(tf_sel_in), .tf_wdata_in(tf_wdata_in),
	.data_wr_in(data_wr_in), .data_in(data_in), .data_req_out(data_req_out),
	.cmd_done_out(cmd_done_out), .media_word_valid_out(media_word_valid_out),
	.media_word_out(media_word_out), .media_commit_out(media_commit_out),
	.media_commit_done_in(media_commit_done_in),
	.media_commit_err_in(media_commit_err_in), .rd_done_out(rd_done_out),
	.rd_unc_out(rd_unc_out), .recover_req_out(recover_req_out),
	.recover_done_in(recover_done_in), .log_valid_out(log_valid_out));
